// File: test/tb.sv
// self-checking testbench for the literal and accumulator move block
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [15:0] instr_word_in = 16'h0000;
    logic instr_valid_in = 1'b0;
    logic ext_set_en_in = 1'b0;
    logic [11:0] index_base_in = 12'h000;
    logic instr_ready_out, retire_out, file_we_out, indexed_out, status_we_out;
    logic [7:0] accum_out, bank_ptr_out, file_data_out;
    logic [11:0] file_addr_out;
    int err_total = 0;
    int compares = 0;
    logic [7:0] exp_acc = 8'h00;
    logic [7:0] exp_bank = 8'h00;

    // free-running core clock
    always #(moves_pkg::CLK_PERIOD_NS / 2) sys_clk_in = ~sys_clk_in;

    literal_and_accumulator_moves i_dut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .instr_word_in(instr_word_in),
        .instr_valid_in(instr_valid_in), .ext_set_en_in(ext_set_en_in),
        .index_base_in(index_base_in), .instr_ready_out(instr_ready_out),
        .retire_out(retire_out), .accum_out(accum_out), .bank_ptr_out(bank_ptr_out),
        .file_we_out(file_we_out), .file_addr_out(file_addr_out),
        .file_data_out(file_data_out), .indexed_out(indexed_out),
        .status_we_out(status_we_out)
    );

    // one compare per kind of result: single-bit flags, data bytes, file addresses
    task automatic chk_bit(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_addr(input string name, input logic [11:0] exp, input logic [11:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // issue one word in a Q1 slot and judge Q3, Q4 and the cycle after
    task automatic run_instr(input logic [15:0] w, input logic e, input logic [11:0] b,
                             input logic we, input logic [11:0] addr, input logic idx);
        int n;
        n = 0;
        ext_set_en_in = e;
        index_base_in = b;
        while (instr_ready_out !== 1'b1 && n < 8) begin
            @(negedge sys_clk_in);
            n++;
        end
        chk_bit("ready_q1", 1'b1, instr_ready_out);
        instr_word_in = w;
        instr_valid_in = 1'b1;
        @(negedge sys_clk_in);
        // scramble the word so a late sample of it shows up
        instr_valid_in = 1'b0;
        instr_word_in = ~w;
        @(negedge sys_clk_in);
        chk_bit("retire_q3", 1'b0, retire_out);
        chk_bit("ready_q3", 1'b0, instr_ready_out);
        @(negedge sys_clk_in);
        chk_bit("retire_q4", 1'b1, retire_out);
        chk_bit("status_we", 1'b0, status_we_out);
        chk_bit("file_we", we, file_we_out);
        if (we) begin
            chk_addr("file_addr", addr, file_addr_out);
            chk_byte("file_data", exp_acc, file_data_out);
            chk_bit("indexed", idx, indexed_out);
        end
        if (w[15:8] == moves_pkg::OPC_LIT_ACC) exp_acc = w[7:0];
        if (w[15:8] == moves_pkg::OPC_BANK_LIT) exp_bank = {4'h0, w[3:0]};
        @(negedge sys_clk_in);
        chk_byte("accum", exp_acc, accum_out);
        chk_byte("bank_ptr", exp_bank, bank_ptr_out);
        chk_bit("file_we_after", 1'b0, file_we_out);
    endtask

    task automatic test_lit_load();
        run_instr(16'h0E5A, 1'b0, 12'h000, 1'b0, 12'h000, 1'b0);
        run_instr(16'h0EFF, 1'b1, 12'h000, 1'b0, 12'h000, 1'b0);
    endtask

    // access bank: low half at page 0, high half at the top page
    task automatic test_store_access();
        run_instr(16'h6E5F, 1'b0, 12'h000, 1'b1, 12'h05F, 1'b0);
        run_instr(16'h6E60, 1'b0, 12'h000, 1'b1, 12'hF60, 1'b0);
        run_instr(16'h6E00, 1'b0, 12'h000, 1'b1, 12'h000, 1'b0);
    endtask

    // indexed mode only at offsets up to 5F, sum wraps at 4096
    task automatic test_store_indexed();
        run_instr(16'h0E3C, 1'b0, 12'h000, 1'b0, 12'h000, 1'b0);
        run_instr(16'h6E20, 1'b1, 12'h100, 1'b1, 12'h120, 1'b1);
        run_instr(16'h6E5F, 1'b1, 12'hFF0, 1'b1, 12'h04F, 1'b1);
        run_instr(16'h6E60, 1'b1, 12'h100, 1'b1, 12'hF60, 1'b0);
    endtask

    // bank pointer upper nibble forced to zero, then used by banked stores
    task automatic test_store_banked();
        run_instr(16'h01F5, 1'b0, 12'h000, 1'b0, 12'h000, 1'b0);
        run_instr(16'h6FFF, 1'b0, 12'h000, 1'b1, 12'h5FF, 1'b0);
        run_instr(16'h6F10, 1'b1, 12'h100, 1'b1, 12'h510, 1'b0);
        run_instr(16'h6E30, 1'b0, 12'h000, 1'b1, 12'h030, 1'b0);
    endtask

    initial begin
        repeat (16) @(negedge sys_clk_in);
        rst_in = 1'b0;
        test_lit_load();
        test_store_access();
        test_store_indexed();
        test_store_banked();
        stop_test();
    end

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #20000;
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire

// File: verilog/decode_if.sv
// decoded instruction fields passed from the decoder to the execution logic
`timescale 1ns/100ps
`default_nettype none
interface decode_if;
    logic is_lit_acc;
    logic is_store;
    logic is_bank_lit;
    logic sel_bank;
    logic [7:0] literal;
    logic [7:0] file_off;
    modport drv (output is_lit_acc, is_store, is_bank_lit, sel_bank, literal, file_off);
    modport use_side (input is_lit_acc, is_store, is_bank_lit, sel_bank, literal, file_off);
endinterface
`default_nettype wire

// File: verilog/instr_decoder.sv
// combinational opcode decoder for the move instructions
`timescale 1ns/100ps
`default_nettype none
module instr_decoder (
    input wire logic [15:0] instr_word_in,
    decode_if.drv dec
);
    // opcode compare; literal and file offset share the low byte
    always_comb begin
        dec.is_lit_acc = instr_word_in[moves_pkg::OPC_HI:moves_pkg::OPC8_LO]
                         == moves_pkg::OPC_LIT_ACC;
        dec.is_bank_lit = instr_word_in[moves_pkg::OPC_HI:moves_pkg::OPC8_LO]
                          == moves_pkg::OPC_BANK_LIT;
        dec.is_store = instr_word_in[moves_pkg::OPC_HI:moves_pkg::OPC7_LO]
                       == moves_pkg::OPC_STORE;
        dec.sel_bank = instr_word_in[moves_pkg::SEL_BIT];
        dec.literal = instr_word_in[7:0];
        dec.file_off = instr_word_in[7:0];
    end
endmodule
`default_nettype wire

// File: verilog/literal_and_accumulator_moves.sv
// execution of literal-load, bank-literal and accumulator-store instructions
`timescale 1ns/100ps
`default_nettype none
module literal_and_accumulator_moves (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [15:0] instr_word_in,
    input wire logic instr_valid_in,
    input wire logic ext_set_en_in,
    input wire logic [11:0] index_base_in,
    output logic instr_ready_out,
    output logic retire_out,
    output logic [7:0] accum_out,
    output logic [7:0] bank_ptr_out,
    output logic file_we_out,
    output logic [11:0] file_addr_out,
    output logic [7:0] file_data_out,
    output logic indexed_out,
    output logic status_we_out
);
    moves_pkg::q_phase_e phase_q;
    logic busy_q;
    logic [15:0] ir_q;
    logic [7:0] accum_q;
    logic [7:0] bank_ptr_q;
    logic file_we_q;
    logic [11:0] file_addr_q;
    logic [7:0] file_data_q;
    logic indexed_q;
    logic [11:0] target_d;
    logic indexed_d;

    decode_if dec ();

    instr_decoder u_dec (
        .instr_word_in(ir_q),
        .dec(dec)
    );

    // free-running quarter-cycle sequencer
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_q <= moves_pkg::Q1;
        end else begin
            case (phase_q)
                moves_pkg::Q1: phase_q <= moves_pkg::Q2;
                moves_pkg::Q2: phase_q <= moves_pkg::Q3;
                moves_pkg::Q3: phase_q <= moves_pkg::Q4;
                moves_pkg::Q4: phase_q <= moves_pkg::Q1;
                default: phase_q <= moves_pkg::Q1;
            endcase
        end
    end

    // fetch slot: a word is taken only in Q1 and held until Q4 retires it
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_q <= 1'b0;
            ir_q <= moves_pkg::INSTR_RST;
        end else if (phase_q == moves_pkg::Q1) begin
            busy_q <= instr_valid_in;
            if (instr_valid_in) begin
                ir_q <= instr_word_in;
            end
        end else if (phase_q == moves_pkg::Q4) begin
            busy_q <= 1'b0;
        end
    end

    // target address: access bank split, indexed window or banked page
    always_comb begin
        target_d = {moves_pkg::ACCESS_HI_PAGE, dec.file_off};
        indexed_d = 1'b0;
        if (dec.sel_bank) begin
            target_d = {bank_ptr_q[3:0], dec.file_off};
        end else if (dec.file_off <= moves_pkg::INDEX_LIMIT) begin
            if (ext_set_en_in) begin
                // offset from the index base; wraps within the data space
                target_d = 12'(index_base_in + {4'h0, dec.file_off});
                indexed_d = 1'b1;
            end else begin
                target_d = {moves_pkg::ACCESS_LO_PAGE, dec.file_off};
            end
        end else begin
            target_d = {moves_pkg::ACCESS_HI_PAGE, dec.file_off};
        end
    end

    // store path: address, data and write strobe all load at the end of Q3; the strobe spans Q4
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            file_we_q <= 1'b0;
            file_addr_q <= moves_pkg::ADDR_RST;
            file_data_q <= moves_pkg::ACC_RST;
            indexed_q <= 1'b0;
        end else begin
            file_we_q <= busy_q && dec.is_store && (phase_q == moves_pkg::Q3);
            if (busy_q && dec.is_store && (phase_q == moves_pkg::Q3)) begin
                file_addr_q <= target_d;
                file_data_q <= accum_q;
                indexed_q <= indexed_d;
            end
        end
    end

    // accumulator is written only at the end of Q4 by the literal load
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            accum_q <= moves_pkg::ACC_RST;
        end else if (busy_q && dec.is_lit_acc && (phase_q == moves_pkg::Q4)) begin
            accum_q <= dec.literal;
        end
    end

    // bank pointer keeps only the low nibble so the page index stays in range
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bank_ptr_q <= moves_pkg::BANK_RST;
        end else if (busy_q && dec.is_bank_lit && (phase_q == moves_pkg::Q4)) begin
            bank_ptr_q <= {moves_pkg::BANK_HI_ZERO, dec.literal[3:0]};
        end
    end

    // outputs; none of these moves ever writes the status flags
    assign instr_ready_out = (phase_q == moves_pkg::Q1);
    assign retire_out = busy_q && (phase_q == moves_pkg::Q4);
    assign accum_out = accum_q;
    assign bank_ptr_out = bank_ptr_q;
    assign file_we_out = file_we_q;
    assign file_addr_out = file_addr_q;
    assign file_data_out = file_data_q;
    assign indexed_out = indexed_q;
    assign status_we_out = 1'b0;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    chk_lit_acc_load: assert property (
        retire_out && dec.is_lit_acc |=> accum_q == $past(ir_q[7:0]))
        else $error("literal not loaded into accumulator");
    chk_lit_no_store: assert property (
        busy_q && dec.is_lit_acc |-> !file_we_q && !status_we_out)
        else $error("literal load caused a write");
    chk_lit_one_cycle: assert property (
        instr_ready_out && instr_valid_in && instr_word_in[15:8] == moves_pkg::OPC_LIT_ACC
        |=> busy_q [*3] ##1 !busy_q)
        else $error("literal load not completed in one cycle");
    chk_store_decode: assert property (
        busy_q && ir_q[15:9] == moves_pkg::OPC_STORE && phase_q == moves_pkg::Q3
        |=> file_we_q)
        else $error("store opcode not recognised");
    chk_store_copies: assert property (
        file_we_q |-> file_data_out == accum_q && $stable(accum_q))
        else $error("store data differs from accumulator");
    chk_store_acc_kept: assert property (
        retire_out && dec.is_store |=> $stable(accum_q))
        else $error("store changed accumulator");
    chk_offset_full: assert property (
        file_we_q && !indexed_q |-> file_addr_q[7:0] == ir_q[7:0])
        else $error("in-bank offset wrong");
    chk_access_fixed: assert property (
        file_we_q && !ir_q[8] && !indexed_q
        |-> file_addr_q[11:8] == ((ir_q[7:0] <= moves_pkg::INDEX_LIMIT) ?
            moves_pkg::ACCESS_LO_PAGE : moves_pkg::ACCESS_HI_PAGE))
        else $error("access bank page wrong");
    chk_bank_select: assert property (
        file_we_q && ir_q[8] |-> file_addr_q[11:8] == bank_ptr_q[3:0] && !indexed_q)
        else $error("banked page not from bank pointer");
    chk_indexed_mode: assert property (
        busy_q && dec.is_store && phase_q == moves_pkg::Q3 && !dec.sel_bank
        && ext_set_en_in && dec.file_off <= moves_pkg::INDEX_LIMIT
        |=> indexed_q && file_addr_q == 12'($past(index_base_in) + {4'h0, $past(ir_q[7:0])}))
        else $error("indexed offset mode not used");
    chk_bank_high_zero: assert property (
        bank_ptr_q[7:4] == moves_pkg::BANK_HI_ZERO)
        else $error("bank pointer upper nibble set");

    // side effects: each register moves only when its own instruction retires
    chk_acc_only_lit: assert property (
        !(retire_out && dec.is_lit_acc) |=> $stable(accum_q))
        else $error("accumulator changed outside a literal load");
    chk_bank_only_lit: assert property (
        !(retire_out && dec.is_bank_lit) |=> $stable(bank_ptr_q))
        else $error("bank pointer changed outside a bank literal load");
    chk_bank_load: assert property (
        retire_out && dec.is_bank_lit
        |=> bank_ptr_q == {moves_pkg::BANK_HI_ZERO, ir_q[3:0]})
        else $error("bank pointer low nibble not loaded");

    // write strobe: one clock, and only in Q4 of a decoded store
    chk_we_one_clock: assert property (
        file_we_q |=> !file_we_q)
        else $error("file write strobe longer than one clock");
    chk_we_only_store: assert property (
        file_we_q |-> busy_q && dec.is_store && phase_q == moves_pkg::Q4)
        else $error("file write outside a store");

    // indexed mode needs the extended set and stays inside the low access window
    chk_index_needs_ext: assert property (
        busy_q && dec.is_store && phase_q == moves_pkg::Q3 && !ext_set_en_in
        |=> !indexed_q)
        else $error("indexed mode used with extended set off");
    chk_index_window: assert property (
        file_we_q && indexed_q |-> !ir_q[8] && ir_q[7:0] <= moves_pkg::INDEX_LIMIT)
        else $error("indexed mode outside the low access window");

    cov_lit_load: cover property (retire_out && dec.is_lit_acc);
    cov_store_banked: cover property (file_we_q && ir_q[8]);
    cov_store_indexed: cover property (file_we_q && indexed_q);
    cov_bank_then_store: cover property (
        retire_out && dec.is_bank_lit ##4 file_we_q && ir_q[8]);
    cov_store_access_hi: cover property (
        file_we_q && !ir_q[8] && file_addr_q[11:8] == moves_pkg::ACCESS_HI_PAGE);
endmodule
`default_nettype wire

// File: verilog/moves_pkg.sv
// shared constants and types for the literal and accumulator move block
`default_nettype none
package moves_pkg;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 16;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    // opcode fields
    localparam logic [7:0] OPC_LIT_ACC = 8'h0E;
    localparam logic [7:0] OPC_BANK_LIT = 8'h01;
    localparam logic [6:0] OPC_STORE = 7'h37;
    localparam int SEL_BIT = 8;
    localparam int OPC_HI = 15;
    localparam int OPC8_LO = 8;
    localparam int OPC7_LO = 9;
    // access bank split and pages
    localparam logic [7:0] INDEX_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_LO_PAGE = 4'h0;
    localparam logic [3:0] ACCESS_HI_PAGE = 4'hF;
    localparam logic [3:0] BANK_HI_ZERO = 4'h0;
    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] BANK_RST = 8'h00;
    localparam logic [15:0] INSTR_RST = 16'h0000;
    localparam logic [11:0] ADDR_RST = 12'h000;
    // core clock period
    localparam int CLK_PERIOD_NS = 4;
    // quarter cycles of one instruction cycle
    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} q_phase_e;
endpackage
`default_nettype wire
